// ### card_status_change_irq_config.v
`include "csc_irq_consts.vh"
module card_status_change_irq_config (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_b_i,
    // Indexed register port
    input wire [7:0] reg_index_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // Global controls held elsewhere
    input wire explicit_ack_i,
    input wire ring_ind_en_i,
    input wire io_card_i,
    // Card pins
    input wire card_detect_i,
    input wire card_ready_i,
    input wire batt_warn_b_i,
    input wire batt_dead_stschg_b_i,
    // System interrupt lines
    output reg [15:0] irq_o
);
    // Number of change sources and number of system lines
    localparam NUM_SRC = 4;
    localparam NUM_LINES = 16;
    localparam [7:0] EDGE_KIND = `CSC_EDGE_KINDS;

    // Configuration and flag state
    reg [7:0] cfg;
    reg [3:0] flags;
    reg [3:0] prev;
    reg [2:0] settle;

    // Combinational next values
    reg [3:0] next_flags;
    reg [7:0] next_rdata;
    reg sel_valid;

    // Filtered pins and decoded controls
    wire [3:0] pins_raw;
    wire [3:0] lvl;
    wire [3:0] en_eff;
    wire [3:0] events;
    wire [3:0] vis;
    wire [3:0] sel;
    wire [3:0] clr_mask;
    wire [15:0] next_irq;
    wire primed;
    wire ring_blocks_dead;
    wire hit_status;
    wire hit_config;
    wire rd_status;
    wire wr_status;
    wire wr_config;
    wire any_pending;

    // Pin order matches the bit order of the flag register
    assign pins_raw = {card_detect_i, card_ready_i, batt_warn_b_i, batt_dead_stschg_b_i};

    pin_filter #(
        .WIDTH(NUM_SRC)
    ) u_filter (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .pin_i(pins_raw),
        .level_o(lvl)
    );

    // Settling counter
    // The filter leaves reset at all zeros, so a pin that idles high would
    // look like an edge; edges only count once the filtered level is real
    always @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            settle <= 3'd0;
        end
        else
        begin
            if (settle != `CSC_SETTLE_CYCLES)
                settle <= settle + 3'd1;
        end
    end

    assign primed = (settle == `CSC_SETTLE_CYCLES);

    // Register decode
    assign hit_status = (reg_index_i == `CSC_IDX_STATUS);
    assign hit_config = (reg_index_i == `CSC_IDX_CONFIG);
    assign rd_status = reg_rd_i & hit_status;
    assign wr_status = reg_wr_i & hit_status;
    assign wr_config = reg_wr_i & hit_config;

    // Routing field
    assign sel = cfg[`CSC_SEL_HI:`CSC_SEL_LO];

    // Effective enables
    assign ring_blocks_dead = io_card_i & ring_ind_en_i;
    assign en_eff[`CSC_BIT_DETECT] = cfg[`CSC_BIT_DETECT];
    assign en_eff[`CSC_BIT_READY] = cfg[`CSC_BIT_READY];
    // Warning has no meaning for I/O cards
    assign en_eff[`CSC_BIT_WARN] = cfg[`CSC_BIT_WARN] & ~io_card_i;
    assign en_eff[`CSC_BIT_DEAD] = cfg[`CSC_BIT_DEAD] & ~ring_blocks_dead;

    // Edge detection, one slice per source
    genvar s;
    generate
        for (s = 0; s < NUM_SRC; s = s + 1)
        begin : src
            wire [1:0] kind;
            wire rise;
            wire fall;
            wire hit;
            assign kind = EDGE_KIND[2*s+1:2*s];
            assign rise = lvl[s] & ~prev[s];
            assign fall = ~lvl[s] & prev[s];
            assign hit = (kind == 2'd0) ? (rise | fall) : ((kind == 2'd1) ? rise : fall);
            assign events[s] = primed & hit;
        end
    endgenerate

    // Flag update
    assign vis = flags & en_eff;
    assign clr_mask = wr_status ? reg_wdata_i[3:0] : 4'h0;

    always @*
    begin
        next_flags = flags & ~clr_mask;
        if (rd_status && !explicit_ack_i)
            next_flags = 4'h0;
        // Set beats clear so an edge during an acknowledge is not lost
        next_flags = (next_flags | events) & en_eff;
    end

    // Read data
    always @*
    begin
        case (reg_index_i)
            `CSC_IDX_STATUS: next_rdata = {4'h0, vis};
            `CSC_IDX_CONFIG: next_rdata = {cfg[7:1], cfg[0] & ~ring_blocks_dead};
            default: next_rdata = 8'h00;
        endcase
    end

    // Register state
    always @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            cfg <= `CSC_CFG_RESET;
            flags <= 4'h0;
            prev <= 4'h0;
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            prev <= lvl;
            flags <= next_flags;
            if (wr_config)
                cfg <= reg_wdata_i;
            // Read data holds until the next read so slow hosts can fetch it
            if (reg_rd_i)
                reg_rdata_o <= next_rdata;
        end
    end

    // Reserved codes route nowhere
    always @*
    begin
        case (sel)
            4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf: sel_valid = 1'b1;
            default: sel_valid = 1'b0;
        endcase
    end

    // Taken from the next flags so the line rises in the same cycle as the flag
    assign any_pending = |next_flags;

    // One decode slice per system line
    generate
        for (s = 0; s < NUM_LINES; s = s + 1)
        begin : line
            localparam [3:0] LINE_CODE = s;
            assign next_irq[s] = sel_valid & any_pending & (sel == LINE_CODE);
        end
    endgenerate

    // Level held while any visible flag stands; no re-pulse on new events
    always @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            irq_o <= 16'h0000;
        end
        else
        begin
            irq_o <= next_irq;
        end
    end
endmodule

// ### csc_irq_consts.vh
// Notes on behaviour
// - Bits 7:4 of the configuration register route the interrupt; 0 means no line (reset), and 3,4,5,7,9,10,11,12,14,15 pick that line.
// - Bit 3 enables the card detect change source and resets to zero.
// - Bit 2 enables the ready change source and resets to zero.
// - Bit 1 enables the battery warning source and resets to zero; for I/O cards it reads back as written but acts as zero.
// - Bit 0 enables battery dead (memory) or status change (I/O) and resets to zero; for I/O cards it reads and acts as zero while ring indicate is on.
// - A status change flag reads as zero while its enable bit is clear.
// - Flags clear on a write of one; without explicit acknowledge, any read of the status register clears all flags.
// - The routed interrupt is a level held until every flag is clear, so further changes give no second pulse.
// - Ready change sets on a rising ready; battery dead for I/O cards sets on a falling status change signal.
`ifndef CSC_IRQ_CONSTS_VH
`define CSC_IRQ_CONSTS_VH
`define CSC_IDX_STATUS 8'h04
`define CSC_IDX_CONFIG 8'h05
`define CSC_CFG_RESET 8'h00
`define CSC_SEL_HI 7
`define CSC_SEL_LO 4
`define CSC_BIT_DETECT 3
`define CSC_BIT_READY 2
`define CSC_BIT_WARN 1
`define CSC_BIT_DEAD 0
`define CSC_SYNC_STAGES 3
// Cycles after reset before filtered pins may count as edges
`define CSC_SETTLE_CYCLES 3'd5
// Edge kind per source, two bits each from bit 0 up: 0 any change, 1 rising, 2 falling
`define CSC_EDGE_KINDS 8'h1a
`endif

// ### csc_irq_props.sv
module csc_irq_props (
    // Clock, reset, strobes and controls
    input wire clk_sys_i, rst_b_i, reg_wr_i, reg_rd_i,
    input wire explicit_ack_i, ring_ind_en_i, io_card_i,
    // Register data and interrupt lines
    input wire [7:0] reg_index_i, reg_wdata_i, reg_rdata_o,
    input wire [15:0] irq_o
);
    localparam logic [15:0] VALID = 16'hdeb8;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_rd(ix); reg_rd_i && !reg_wr_i && reg_index_i == ix; endsequence
    sequence s_wr_gap(ok); reg_wr_i && reg_index_i == 8'h05 && ok ##1 !reg_wr_i; endsequence
    property p_oh; $onehot0(irq_o); endproperty
    a_oh: assert property (p_oh) else $error("irq lines not one-hot");
    property p_rsv; (irq_o & 16'h2147) == 16'h0000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved irq line driven");
    property p_cfg; s_wr_gap(1'b1) ##1 s_rd(8'h05) |=> reg_rdata_o[7:1] == $past(reg_wdata_i[7:1], 3); endproperty
    a_cfg: assert property (p_cfg) else $error("config readback wrong");
    property p_shi; s_rd(8'h04) |=> reg_rdata_o[7:4] == 4'h0; endproperty
    a_shi: assert property (p_shi) else $error("status high bits set");
    property p_nol; s_wr_gap(!VALID[reg_wdata_i[7:4]]) |=> irq_o == 16'h0000; endproperty
    a_nol: assert property (p_nol) else $error("irq with no line selected");
    property p_clr; s_rd(8'h04) ##0 !explicit_ack_i ##1 !reg_wr_i ##1 s_rd(8'h04) |=> reg_rdata_o == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("read did not clear flags");
    property p_hold; !$past(reg_wr_i) && !reg_wr_i && !reg_rd_i && irq_o != 0 |=> $stable(irq_o); endproperty
    a_hold: assert property (p_hold) else $error("irq changed while pending");
    property p_ring; io_card_i && ring_ind_en_i && reg_rd_i && reg_index_i == 8'h05 |=> !reg_rdata_o[0]; endproperty
    a_ring: assert property (p_ring) else $error("bit0 not zero with ring");
endmodule
bind card_status_change_irq_config csc_irq_props u_props (.*);

// ### irq_sink.sv
module irq_sink (
    input wire logic clk_sys_i,
    input wire logic [15:0] irq_i,
    output int edges_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev = 1'b0;
    initial edges_o = 0;
    // Edge-counting sink: only a fresh rise counts as a new request
    always @(posedge clk_sys_i)
    begin
        prev <= |irq_i;
        if (|irq_i && !prev) edges_o <= edges_o + 1;
    end
endmodule

// ### pin_filter.v
`include "csc_irq_consts.vh"
module pin_filter #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_b_i,
    // Raw pins and filtered levels
    input wire [WIDTH-1:0] pin_i,
    output wire [WIDTH-1:0] level_o
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : bit_sync
            reg [`CSC_SYNC_STAGES-1:0] stage;
            reg level;
            always @(posedge clk_sys_i)
            begin
                if (!rst_b_i)
                begin
                    stage <= 3'b000;
                    level <= 1'b0;
                end
                else
                begin
                    stage <= {stage[1:0], pin_i[g]};
                    // Only the agreeing later stages are looked at; stage 0 may be metastable
                    if (stage[1] == stage[2])
                        level <= stage[2];
                end
            end
            assign level_o[g] = level;
        end
    endgenerate
endmodule

// ### testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic explicit_ack_i = 0, ring_ind_en_i = 0, io_card_i = 0;
    logic [7:0] reg_index_i = 8'h00, reg_wdata_i = 8'h00, rd;
    logic [3:0] pin = 4'b1011;
    wire [7:0] reg_rdata_o;
    wire [15:0] irq_o;
    int err_total = 0, total_checks = 0, edges, n, e;
    int line_of[16] = '{-1, -1, -1, 3, 4, 5, -1, 7, -1, 9, 10, 11, 12, -1, 14, 15};
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    card_status_change_irq_config uut (.card_detect_i(pin[3]), .card_ready_i(pin[2]),
        .batt_warn_b_i(pin[1]), .batt_dead_stschg_b_i(pin[0]), .*);
    irq_sink sink (.clk_sys_i, .irq_i(irq_o), .edges_o(edges));
    task chk(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [7:0] a, d);
        @(posedge clk_sys_i);
        {reg_index_i, reg_wdata_i, reg_wr_i, reg_rd_i} <= {a, d, w, !w};
        @(posedge clk_sys_i);
        {reg_wr_i, reg_rd_i} <= 2'b00;
        #1 rd = reg_rdata_o;
    endtask
    // Idle pin levels are chosen so that inverting a pin away from its idle level is always its event edge
    task pulse(input int i);
        @(posedge clk_sys_i);
        pin[i] <= ~pin[i];
        repeat (8) @(posedge clk_sys_i);
        #1;
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        void'($urandom(29852));
        repeat (8) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        acc(0, 8'h05, 8'h00); chk(rd, 16'h0000);
        for (n = 0; n < 32; n++)
        begin
            e = $urandom % 16;
            if (n < 16) e[n % 4] = 1;
            acc(1, 8'h05, {n[3:0], e[3:0]});
            acc(0, 8'h05, 8'h00); chk(rd, {n[3:0], e[3:0]});
            pulse(n % 4);
            pulse(n % 4);
            chk(irq_o, e[n % 4] && line_of[n % 16] >= 0 ? 1 << line_of[n % 16] : 0);
            acc(0, 8'h04, 8'h00); chk(rd, e[n % 4] << (n % 4));
            acc(0, 8'h04, 8'h00); chk(rd, 16'h0000);
            chk(irq_o, 16'h0000);
        end
        explicit_ack_i <= 1'b1;
        acc(1, 8'h05, 8'h5c);
        n = edges;
        pulse(2); pulse(2); pulse(3); pulse(3);
        chk(edges - n, 16'h0001);
        acc(1, 8'h04, 8'h04); #5 chk(irq_o, 16'h0020);
        acc(1, 8'h04, 8'h08); #5 chk(irq_o, 16'h0000);
        {io_card_i, ring_ind_en_i} <= 2'b11;
        acc(1, 8'h05, 8'h51); acc(0, 8'h05, 8'h00); chk(rd, 16'h0050);
        acc(1, 8'h05, 8'h53); pulse(1); pulse(1); pulse(0); pulse(0);
        chk(irq_o, 16'h0000);
        ring_ind_en_i <= 1'b0;
        pulse(0); pulse(0); chk(irq_o, 16'h0020);
        acc(0, 8'h04, 8'h00); chk(rd, 16'h0001);
        end_sim;
    end
endmodule
